/* verilog/mode_control_pkg.sv */
package mode_control_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IDENTITY_REGISTER_ADDR = 8'h00;
  localparam logic [7:0] MODE_CONTROL_ADDR      = 8'h01;
  localparam logic [7:0] INT_STATUS_ADDR        = 8'h02;
  localparam logic [7:0] INT_ENABLE_ADDR        = 8'h03;
  localparam logic [7:0] MODE_CONTROL_RESET     = 8'h00;
  localparam logic [5:0] INT_RESET              = 6'h00;
  localparam logic [1:0] INT_PAD                = 2'h0;
  localparam logic [7:0] UNMAPPED_READ          = 8'h00;

  // ----------------------------------------------------------------
  // mode_control field positions
  // ----------------------------------------------------------------
  localparam int SINK7_LIGHT_AUTO_BIT = 7;
  localparam int INT_RETRIGGER_BIT    = 6;
  localparam int ACTIVE_BIT           = 5;
  localparam int DIM_ACTIVE_BIT       = 4;
  localparam int GAIN_INHIBIT_BIT     = 3;
  localparam int SYNC_SINK_BIT        = 2;
  localparam int CMP_AUTO_BIT         = 1;
  localparam int BACKLIGHT_EN_BIT     = 0;
  localparam int SINK_COUNT           = 7;
  localparam int SINK_SEVEN           = 6;
  localparam int EVENT_COUNT          = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int RETRIGGER_GAP_US = 50;
  localparam int CLOCK_MHZ        = 50;
  localparam int RETRIGGER_CYCLES = RETRIGGER_GAP_US * CLOCK_MHZ;
  localparam int GAP_WIDTH        = 12;

  // ----------------------------------------------------------------
  // serial bus
  // ----------------------------------------------------------------
  localparam logic [6:0] BUS_ADDRESS  = 7'h2a;
  localparam logic [3:0] BIT_COUNT    = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ZONE_OUTDOOR,
    ZONE_BRIGHT,
    ZONE_OFFICE,
    ZONE_INDOOR,
    ZONE_DARK
  } zone_t;

  typedef enum logic [1:0] {
    GAIN_1X,
    GAIN_1P5X,
    GAIN_2X
  } gain_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic  on;
    logic  dim;
    logic  auto_level;
    zone_t level;
  } backlight_out_t;

endpackage

/* verilog/serial_target.sv */
`timescale 1ns/1ps
module serial_target
  import mode_control_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  output reg_access_t      access,
  input  wire logic [7:0]  rdata
);

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK,
    S_WDATA, S_WACK, S_RDATA, S_RACK
  } bus_state_t;

  typedef struct packed {
    logic        scl_q;
    logic        sda_q;
    bus_state_t  st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        rw;
    logic        nack;
    logic        drv;
    reg_access_t acc;
  } target_t;

  target_t s, next_s;
  logic    rise, fall, start, stop;

  always_comb
  begin
    rise  = scl & ~s.scl_q;
    fall  = ~scl & s.scl_q;
    start = scl & s.scl_q & s.sda_q & ~sda_in;
    stop  = scl & s.scl_q & ~s.sda_q & sda_in;
    next_s        = s;
    next_s.scl_q  = scl;
    next_s.sda_q  = sda_in;
    next_s.acc.wr = 1'b0;
    if (start)
    begin
      next_s.st  = S_ADDR;
      next_s.cnt = '0;
      next_s.drv = 1'b0;
    end
    else if (stop)
    begin
      next_s.st  = S_IDLE;
      next_s.drv = 1'b0;
    end
    else
    begin
      unique case (s.st)
        S_IDLE: ;
        S_ADDR, S_REG, S_WDATA:
        begin
          if (rise)
          begin
            next_s.sh  = {s.sh[6:0], sda_in};
            next_s.cnt = s.cnt + 4'h1;
          end
          else if (fall && s.cnt == BIT_COUNT)
          begin
            next_s.cnt = '0;
            next_s.drv = 1'b1;
            if (s.st == S_ADDR)
            begin
              next_s.rw = s.sh[0];
              next_s.st = S_ADDR_ACK;
              if (s.sh[7:1] != BUS_ADDRESS)
              begin
                next_s.st  = S_IDLE;
                next_s.drv = 1'b0;
              end
            end
            else if (s.st == S_REG)
            begin
              next_s.ptr = s.sh;
              next_s.st  = S_REG_ACK;
            end
            else
            begin
              next_s.acc.wr    = 1'b1;
              next_s.acc.wdata = s.sh;
              next_s.st        = S_WACK;
            end
          end
        end
        S_ADDR_ACK, S_REG_ACK, S_WACK:
        begin
          if (fall)
          begin
            next_s.drv = 1'b0;
            next_s.st  = (s.st == S_ADDR_ACK) ? S_REG : S_WDATA;
            // step the pointer only once the written byte is acked
            if (s.st == S_WACK)
              next_s.ptr = s.ptr + 8'h01;
            if (s.st == S_ADDR_ACK && s.rw)
            begin
              next_s.sh  = rdata;
              next_s.drv = ~rdata[7];
              next_s.ptr = s.ptr + 8'h01;
              next_s.st  = S_RDATA;
            end
          end
        end
        S_RDATA:
        begin
          if (rise)
            next_s.cnt = s.cnt + 4'h1;
          else if (fall)
          begin
            if (s.cnt == BIT_COUNT)
            begin
              next_s.drv = 1'b0;
              next_s.st  = S_RACK;
            end
            else
            begin
              next_s.drv = ~s.sh[6];
              next_s.sh  = {s.sh[6:0], 1'b0};
            end
          end
        end
        S_RACK:
        begin
          if (rise)
            next_s.nack = sda_in;
          else if (fall)
          begin
            next_s.cnt = '0;
            if (s.nack)
              next_s.st = S_IDLE;
            else
            begin
              next_s.sh  = rdata;
              next_s.drv = ~rdata[7];
              next_s.ptr = s.ptr + 8'h01;
              next_s.st  = S_RDATA;
            end
          end
        end
        default:
          next_s.st = S_IDLE;
      endcase
    end
    // reads and writes both address the register pointer
    next_s.acc.addr = next_s.ptr;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s       <= '0;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.st    <= S_IDLE;
    end
    else
      s <= next_s;
  end

  // open drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~s.drv;
  assign access   = s.acc;

endmodule // serial_target

/* verilog/mode_control_registers.sv */
`timescale 1ns/1ps
module mode_control_registers
  import mode_control_pkg::*;
#(
  parameter logic [3:0] MAKER_CODE    = 4'h5,  // arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h2   // arbitrary value
)
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    scl,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n,
  input  wire logic [EVENT_COUNT-1:0]  event_in,
  input  wire logic                    dim_timeout,
  input  wire zone_t                   comparator_zone,
  input  wire logic [3:0]              zone_level_enable,
  input  wire zone_t                   manual_level_select,
  input  wire logic [SINK_COUNT-1:0]   independent_sink,
  input  wire logic [SINK_COUNT-1:0]   per_sink_enable,
  input  wire gain_t                   gain_demand,
  input  wire logic                    all_leds_off,
  output logic                         int_n,
  output logic                         core_active,
  output backlight_out_t               backlight,
  output logic [SINK_COUNT-1:0]        sink_on,
  output logic                         sink7_ambient,
  output zone_t                        sink7_zone,
  output gain_t                        pump_gain
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]             mode;
    logic [EVENT_COUNT-1:0] status;
    logic [EVENT_COUNT-1:0] enable;
    logic [GAP_WIDTH-1:0]   gap;
    logic                   irq;
    logic                   active;
    backlight_out_t         bl;
    logic [SINK_COUNT-1:0]  sinks;
    logic                   s7_amb;
    zone_t                  s7_zone;
    gain_t                  gain;
  } regs_t;

  localparam logic [GAP_WIDTH-1:0] GAP_LOAD =
    GAP_WIDTH'(RETRIGGER_CYCLES);
  localparam logic [GAP_WIDTH-1:0] GAP_ONE  = GAP_WIDTH'(1);

  regs_t       r, next_r;
  reg_access_t access;
  logic [7:0]  rdata;

  function automatic logic is_write(input reg_access_t a,
                                    input logic [7:0]  addr);
    is_write = a.wr && (a.addr == addr);
  endfunction

  // ----------------------------------------------------------------
  // serial bus target
  // ----------------------------------------------------------------
  serial_target serial_target_i
  (
    .mclk     (mclk),
    .rst      (rst),
    .scl      (scl),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe_n (sda_oe_n),
    .access   (access),
    .rdata    (rdata)
  );

  // reads have no side effects
  always_comb
  begin
    unique case (access.addr)
      IDENTITY_REGISTER_ADDR: rdata = {MAKER_CODE, REVISION_CODE};
      MODE_CONTROL_ADDR:      rdata = r.mode;
      INT_STATUS_ADDR:        rdata = {INT_PAD, r.status};
      INT_ENABLE_ADDR:        rdata = {INT_PAD, r.enable};
      default:                rdata = UNMAPPED_READ;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [EVENT_COUNT-1:0] clear_mask;
  logic [EVENT_COUNT-1:0] pending;
  logic                   bl_on;
  logic                   auto_ok;
  logic                   any_sink_en;

  always_comb
  begin
    next_r = r;

    // identity writes fall through: no register is touched
    if (is_write(access, MODE_CONTROL_ADDR))
      next_r.mode = access.wdata;
    // hardware set wins over a host write of zero
    if (dim_timeout)
      next_r.mode[DIM_ACTIVE_BIT] = 1'b1;

    if (is_write(access, INT_ENABLE_ADDR))
      next_r.enable = access.wdata[EVENT_COUNT-1:0];

    clear_mask = '0;
    if (is_write(access, INT_STATUS_ADDR))
      clear_mask = access.wdata[EVENT_COUNT-1:0];
    next_r.status = (r.status & ~clear_mask) | event_in;
    pending = next_r.status & next_r.enable;

    // interrupt line with optional high gap on int_n after a clear attempt
    if (r.gap != '0)
    begin
      next_r.gap = r.gap - GAP_ONE;
      next_r.irq = 1'b0;
      if (r.gap == GAP_ONE)
        next_r.irq = |pending;
    end
    else if ((clear_mask & r.status) != '0 && (|pending) && r.irq &&
             r.mode[INT_RETRIGGER_BIT])
    begin
      next_r.gap = GAP_LOAD;
      next_r.irq = 1'b0;
    end
    else
      next_r.irq = |pending;

    // standby and backlight
    next_r.active = r.mode[ACTIVE_BIT];
    bl_on = r.mode[BACKLIGHT_EN_BIT] & r.mode[ACTIVE_BIT];
    next_r.bl.on  = bl_on;
    next_r.bl.dim = r.mode[DIM_ACTIVE_BIT] & bl_on;

    // level selection
    auto_ok = r.mode[CMP_AUTO_BIT] & (|zone_level_enable);
    next_r.bl.auto_level = auto_ok;
    next_r.bl.level = auto_ok ? comparator_zone
                              : manual_level_select;

    // sink seven ambient control
    next_r.s7_amb = r.mode[SINK7_LIGHT_AUTO_BIT] &
                    independent_sink[SINK_SEVEN] & auto_ok &
                    r.mode[ACTIVE_BIT];
    next_r.s7_zone = next_r.s7_amb ? comparator_zone
                                   : ZONE_OUTDOOR;

    // independent sinks
    any_sink_en = |per_sink_enable;
    if (!r.mode[ACTIVE_BIT])
      next_r.sinks = '0;
    else if (any_sink_en)
      next_r.sinks = per_sink_enable & independent_sink;
    else if (r.mode[SYNC_SINK_BIT])
      next_r.sinks = independent_sink;
    else
      next_r.sinks = '0;

    // charge pump gain policy
    if (!r.mode[GAIN_INHIBIT_BIT])
      next_r.gain = gain_demand;
    else if (gain_demand > r.gain || all_leds_off)
      next_r.gain = gain_demand;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      r          <= '0;
      r.mode     <= MODE_CONTROL_RESET;
      r.status   <= INT_RESET;
      r.enable   <= INT_RESET;
      r.bl.level <= ZONE_OUTDOOR;
      r.s7_zone  <= ZONE_OUTDOOR;
      r.gain     <= GAIN_1X;
    end
    else
      r <= next_r;
  end

  assign int_n         = ~r.irq;
  assign core_active   = r.active;
  assign backlight     = r.bl;
  assign sink_on       = r.sinks;
  assign sink7_ambient = r.s7_amb;
  assign sink7_zone    = r.s7_zone;
  assign pump_gain     = r.gain;

endmodule // mode_control_registers

/* testbench/mode_control_registers_asserts.sv */
`timescale 1ns/1ps
module mode_control_registers_asserts
  import mode_control_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire zone_t                 comparator_zone,
  input wire zone_t                 manual_level_select,
  input wire logic [3:0]            zone_level_enable,
  input wire logic [SINK_COUNT-1:0] independent_sink,
  input wire logic [SINK_COUNT-1:0] per_sink_enable,
  input wire gain_t                 gain_demand,
  input wire logic                  dim_timeout,
  input wire logic                  core_active,
  input wire backlight_out_t        backlight,
  input wire logic [SINK_COUNT-1:0] sink_on,
  input wire logic                  sink7_ambient,
  input wire zone_t                 sink7_zone,
  input wire gain_t                 pump_gain
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence dim_seen;
    dim_timeout ##1 backlight.on [*2];
  endsequence

  chk_bl_active: assert property (backlight.on |-> core_active)
    else $error("backlight on in standby");
  chk_standby_idle: assert property (
    !core_active |-> sink_on == '0 && !sink7_ambient)
    else $error("sinks on in standby");
  chk_dim_needs_bl: assert property (backlight.dim |-> backlight.on)
    else $error("dim without backlight");
  chk_dim_timeout: assert property (dim_seen |-> backlight.dim)
    else $error("dim timeout ignored");
  chk_manual_level: assert property (
    backlight.on && !backlight.auto_level
    |-> backlight.level == $past(manual_level_select))
    else $error("manual level not followed");
  chk_auto_level: assert property (
    backlight.on && backlight.auto_level && $past(|zone_level_enable)
    |-> backlight.level == $past(comparator_zone))
    else $error("comparator level not followed");
  chk_sink7_zone: assert property (sink7_ambient |->
    sink7_zone == $past(comparator_zone)
    && $past(independent_sink[SINK_SEVEN]))
    else $error("sink seven zone wrong");
  chk_sink7_plain: assert property (
    !sink7_ambient |-> sink7_zone == ZONE_OUTDOOR)
    else $error("sink seven zone without ambient");
  chk_gain_step: assert property (
    $changed(pump_gain) |-> pump_gain == $past(gain_demand))
    else $error("pump gain off demand");
  chk_sink_per: assert property (
    core_active && $past(|per_sink_enable)
    |-> sink_on == $past(per_sink_enable & independent_sink))
    else $error("per sink enables not honoured");
  chk_sink_indep: assert property (
    (sink_on & ~$past(independent_sink)) == '0)
    else $error("non independent sink on");
endmodule  // mode_control_registers_asserts

bind mode_control_registers mode_control_registers_asserts
  mode_control_registers_asserts_i (
  .mclk(mclk), .rst(rst), .comparator_zone(comparator_zone),
  .manual_level_select(manual_level_select),
  .zone_level_enable(zone_level_enable),
  .independent_sink(independent_sink), .per_sink_enable(per_sink_enable),
  .gain_demand(gain_demand), .dim_timeout(dim_timeout),
  .core_active(core_active), .backlight(backlight), .sink_on(sink_on),
  .sink7_ambient(sink7_ambient), .sink7_zone(sink7_zone),
  .pump_gain(pump_gain));

/* testbench/bus_host.sv */
`timescale 1ns/1ps
module bus_host
  import mode_control_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // ------------------------------------------------
  // phases held 5 mclk, sda moves with scl low except in start and stop
  // ------------------------------------------------
  task automatic set(input logic c, input logic d);
    scl = c;
    sda_low = d;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  task automatic start();
    set(1'b0, sda_low);
    set(1'b0, 1'b0);
    set(1'b1, 1'b0);
    set(1'b1, 1'b1);
  endtask

  task automatic stop();
    set(1'b0, sda_low);
    set(1'b0, 1'b1);
    set(1'b1, 1'b1);
    set(1'b1, 1'b0);
  endtask

  task automatic bit_io(input logic b, output logic s);
    set(1'b0, sda_low);
    set(1'b0, ~b);
    set(1'b1, ~b);
    s = sda;
  endtask

  task automatic byte_io(input logic [7:0] d, input logic m,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(m, ack);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                    input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic [2:0] k;
    start();
    byte_io({dev, 1'b0}, 1'b1, q, k[0]);
    byte_io(a, 1'b1, q, k[1]);
    byte_io(d, 1'b1, q, k[2]);
    stop();
    nak = |k;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic [7:0] x;
    logic       k;
    start();
    byte_io({BUS_ADDRESS, 1'b0}, 1'b1, x, k);
    byte_io(a, 1'b1, x, k);
    start();
    byte_io({BUS_ADDRESS, 1'b1}, 1'b1, x, k);
    byte_io(8'hff, 1'b1, q, k);
    stop();
  endtask
endmodule  // bus_host

/* testbench/mode_control_registers_tb.sv */
`timescale 1ns/1ps
module mode_control_registers_tb
  import mode_control_pkg::*;
;
  localparam logic [3:0] MAKER = 4'h6;  // arbitrary value
  localparam logic [3:0] REV   = 4'h4;  // arbitrary value
  localparam logic [7:0] MC    = MODE_CONTROL_ADDR;
  localparam logic [7:0] ST    = INT_STATUS_ADDR;
  logic                   mclk = 1'b0;
  logic                   rst = 1'b1;
  logic                   scl, sda_low, sda, sda_out, sda_oe_n;
  logic [EVENT_COUNT-1:0] event_in = '0;
  logic                   dim_timeout = 1'b0;
  zone_t                  comparator_zone = ZONE_OUTDOOR;
  zone_t                  manual_level_select = ZONE_OUTDOOR;
  logic [3:0]             zone_level_enable = '0;
  logic [SINK_COUNT-1:0]  independent_sink = '0, per_sink_enable = '0;
  gain_t                  gain_demand = GAIN_1X;
  logic                   all_leds_off = 1'b0;
  logic                   int_n, core_active, sink7_ambient;
  backlight_out_t         backlight;
  logic [SINK_COUNT-1:0]  sink_on;
  zone_t                  sink7_zone;
  gain_t                  pump_gain;
  logic [7:0]             rv;
  int                     num_errors = 0, cmp_count = 0, cycles = 0;
  int                     hi = 0, last_hi = 0, cap;

  always #10 mclk = ~mclk;
  assign sda = ~(sda_low | ~sda_oe_n);  // pull-up on the wire

  mode_control_registers #(.MAKER_CODE(MAKER), .REVISION_CODE(REV))
  mode_control_registers_i (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .event_in(event_in), .dim_timeout(dim_timeout),
    .comparator_zone(comparator_zone), .zone_level_enable(zone_level_enable),
    .manual_level_select(manual_level_select),
    .independent_sink(independent_sink), .per_sink_enable(per_sink_enable),
    .gain_demand(gain_demand), .all_leds_off(all_leds_off), .int_n(int_n),
    .core_active(core_active), .backlight(backlight), .sink_on(sink_on),
    .sink7_ambient(sink7_ambient), .sink7_zone(sink7_zone),
    .pump_gain(pump_gain));

  bus_host bus_host_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // ------------------------------------------------
  // helpers; hi/last_hi measure released interrupt runs
  // ------------------------------------------------
  always @(posedge mclk)
  begin
    cycles++;
    last_hi = (int_n !== 1'b1 && hi != 0) ? hi : last_hi;
    hi = (int_n === 1'b1) ? hi + 1 : 0;
    if (cycles == 40000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic c8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic k;
    bus_host_i.wr(BUS_ADDRESS, a, d, k);
    c8("ack", 8'h0, 8'(k));
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_regs();
    logic k;
    bus_host_i.rd(IDENTITY_REGISTER_ADDR, rv);
    c8("identity", {MAKER, REV}, rv);
    w(IDENTITY_REGISTER_ADDR, 8'hff);
    bus_host_i.rd(IDENTITY_REGISTER_ADDR, rv);
    c8("identity kept", {MAKER, REV}, rv);
    bus_host_i.rd(MC, rv);
    c8("mode reset", MODE_CONTROL_RESET, rv);
    bus_host_i.rd(8'h10, rv);
    c8("unmapped", UNMAPPED_READ, rv);
    bus_host_i.wr(BUS_ADDRESS + 7'h1, MC, 8'h21, k);
    c8("foreign nak", 8'h1, 8'(k));
    c8("sda out", 8'h0, 8'(sda_out));
    c8("standby", 8'h0, 8'(core_active));
  endtask

  task automatic t_level();
    manual_level_select = ZONE_INDOOR;
    comparator_zone = ZONE_DARK;
    w(MC, 8'h01);
    c8("on standby", 8'h0, 8'(backlight.on));
    w(MC, 8'h21);
    c8("on", 8'h1, 8'(backlight.on));
    c8("active", 8'h1, 8'(core_active));
    c8("manual", 8'(ZONE_INDOOR), 8'(backlight.level));
    w(MC, 8'h23);
    c8("no zone", 8'(ZONE_INDOOR), 8'(backlight.level));
    zone_level_enable = 4'h2;
    tick(2);
    c8("auto", 8'(ZONE_DARK), 8'(backlight.level));
  endtask

  task automatic t_dim();
    dim_timeout = 1'b1;
    tick(1);
    dim_timeout = 1'b0;
    tick(3);
    c8("dim hw", 8'h1, 8'(backlight.dim));
    bus_host_i.rd(MC, rv);
    c8("dim bit", 8'h33, rv);
    w(MC, 8'h30);
    c8("dim no bl", 8'h0, 8'(backlight.dim));
    w(MC, 8'h31);
    c8("dim host", 8'h1, 8'(backlight.dim));
  endtask

  task automatic t_sink();
    independent_sink = 7'h45;
    w(MC, 8'h24);
    c8("sync on", 8'h45, 8'(sink_on));
    w(MC, 8'h20);
    c8("sync off", 8'h00, 8'(sink_on));
    per_sink_enable = 7'h0f;
    w(MC, 8'h24);
    c8("per sink", 8'h05, 8'(sink_on));
    w(MC, 8'h20);
    c8("per sink kept", 8'h05, 8'(sink_on));
    per_sink_enable = '0;
  endtask

  task automatic t_sink7();
    independent_sink = 7'h40;
    comparator_zone = ZONE_OFFICE;
    w(MC, 8'ha2);
    c8("s7 ambient", 8'h1, 8'(sink7_ambient));
    comparator_zone = ZONE_BRIGHT;
    tick(2);
    c8("s7 zone", 8'(ZONE_BRIGHT), 8'(sink7_zone));
    w(MC, 8'h22);
    c8("s7 plain", 8'h0, 8'(sink7_ambient));
  endtask

  task automatic t_gain();
    w(MC, 8'h28);
    gain_demand = GAIN_2X;
    tick(2);
    c8("gain up", 8'(GAIN_2X), 8'(pump_gain));
    gain_demand = GAIN_1X;
    tick(3);
    c8("gain held", 8'(GAIN_2X), 8'(pump_gain));
    all_leds_off = 1'b1;
    tick(2);
    c8("gain down", 8'(GAIN_1X), 8'(pump_gain));
    all_leds_off = 1'b0;
    w(MC, 8'h20);
    gain_demand = GAIN_1P5X;
    tick(2);
    c8("gain rise", 8'(GAIN_1P5X), 8'(pump_gain));
    gain_demand = GAIN_1X;
    tick(2);
    c8("gain fall", 8'(GAIN_1X), 8'(pump_gain));
  endtask

  task automatic t_int();
    w(INT_ENABLE_ADDR, 8'h03);
    event_in = 6'h03;
    tick(1);
    event_in = '0;
    tick(3);
    cap = last_hi;
    w(ST, 8'h01);
    c8("irq held", 8'h1, 8'(int_n === 1'b0 && last_hi == cap));
    bus_host_i.rd(ST, rv);
    c8("w1c", 8'h02, rv);
    w(ST, 8'h00);
    bus_host_i.rd(ST, rv);
    c8("w0 kept", 8'h02, rv);
    w(ST, 8'h02);
    c8("irq clear", 8'h1, 8'(int_n));
    w(MC, 8'h60);
    event_in = 6'h03;
    tick(1);
    event_in = '0;
    w(ST, 8'h01);
    for (int i = 0; i < 3000 && int_n !== 1'b0; i++)
      tick(1);
    tick(1);
    c8("gap", 8'h1, 8'(last_hi >= RETRIGGER_CYCLES - 1
                       && last_hi <= RETRIGGER_CYCLES + 1));
  endtask

  initial
  begin
    tick(3);
    rst = 1'b0;
    tick(1);
    t_regs();
    t_level();
    t_dim();
    t_sink();
    t_sink7();
    t_gain();
    t_int();
    wrap_up();
  end
endmodule  // mode_control_registers_tb
